/* ssm_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_i2c_slave #(
  parameter int FILT = ssm_pkg::FILT_CYCLES,
  parameter int DEPTH = ssm_pkg::SAMPLE_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_strap_low,
  input wire logic [1:0] addr_strap_high,
  input wire logic reboot_busy,
  input wire logic ten_bit_mode,
  input wire logic smp_wr,
  input wire logic [1:0] smp_sel,
  input wire logic [ssm_pkg::SAMPLE_W-1:0] smp_data,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic cbuf_active
);
  import ssm_pkg::*;
  localparam int KW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ssm_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_in_reg, shift_in_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic sda_oe_n_reg, sda_oe_n_next;
  logic sda_out_reg;
  logic rw_reg, rw_next;
  logic first_byte_reg, first_byte_next;
  logic reject_reg, reject_next;
  logic [7:0] ptr_reg, ptr_next;
  logic cbuf_reg, cbuf_next;
  logic [KW-1:0] samp_k_reg, samp_k_next;
  logic hi_phase_reg, hi_phase_next;
  logic ack_seen_reg, ack_seen_next;
  logic reg_wr_en_reg, reg_wr_en_next;
  logic [7:0] reg_wr_addr_reg, reg_wr_addr_next;
  logic [7:0] reg_wr_data_reg, reg_wr_data_next;
  logic [1:0] strap_lo_s1_reg, strap_lo_s2_reg;
  logic [1:0] strap_hi_s1_reg, strap_hi_s2_reg;
  logic [SAMPLE_W-1:0] sample_word;
  // buffer index follows the loaded base: 0x46 selects buffer 0
  wire [1:0] buf_sel = 2'(ptr_reg - PTR_BUF_FIRST);
  ssm_line_if line ();

  // ----------------------------------------------------------------
  // line conditioning and sample storage
  // ----------------------------------------------------------------
  ssm_line_cond #(.FILT(FILT)) u_line (
    .clk(clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line.src)
  );

  ssm_sample_buf #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH), .NBUF(BUF_COUNT)) u_buf (
    .clk(clk),
    .reset(reset),
    .wr_en(smp_wr),
    .wr_sel(smp_sel),
    .wr_data(smp_data),
    .rd_sel(buf_sel),
    .rd_k(samp_k_reg),
    .rd_data(sample_word)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // low strap maps to 2'b10, high to 2'b01, open to 2'b00
  function automatic logic [1:0] strap_bits(input logic [1:0] code);
    case (code)
      STRAP_LOW: strap_bits = 2'h2;
      STRAP_HIGH: strap_bits = 2'h1;
      default: strap_bits = 2'h0;
    endcase
  endfunction : strap_bits

  wire [6:0] own_addr = {SLAVE_PREFIX, strap_bits(strap_hi_s2_reg),
                         strap_bits(strap_lo_s2_reg)};
  wire addr_match = (shift_in_reg[7:1] == own_addr) && !reboot_busy;
  wire byte_done = (bit_cnt_reg == BITS_PER_BYTE);
  wire rx_is_cfg = (shift_in_reg <= PTR_CFG_MAX);
  wire rx_is_buf = (shift_in_reg >= PTR_BUF_FIRST) && (shift_in_reg <= PTR_BUF_LAST);
  wire [7:0] ptr_incr = (ptr_reg >= PTR_CFG_MAX) ? PTR_RESET : ptr_reg + 8'h01;
  wire [KW-1:0] samp_k_incr = (samp_k_reg == KW'(DEPTH - 1)) ? '0 : samp_k_reg + KW'(1);
  // 10-bit low phase sends the two low bits right-justified; else top eight bits
  wire [7:0] samp_byte = (ten_bit_mode && !hi_phase_reg) ? {6'h00, sample_word[1:0]}
                                                        : sample_word[9:2];
  wire [7:0] tx_byte = cbuf_reg ? samp_byte : reg_rd_data;
  wire bus_event = line.start_det | line.stop_det;

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  // data changes only on clock falls, sampling only on rises; the master
  // owns the clock, so nothing here waits on a time-out
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_in_next = shift_in_reg;
    tx_shift_next = tx_shift_reg;
    sda_oe_n_next = sda_oe_n_reg;
    rw_next = rw_reg;
    first_byte_next = first_byte_reg;
    reject_next = reject_reg;
    ptr_next = ptr_reg;
    cbuf_next = cbuf_reg;
    samp_k_next = samp_k_reg;
    hi_phase_next = hi_phase_reg;
    ack_seen_next = ack_seen_reg;
    reg_wr_en_next = 1'b0;
    reg_wr_addr_next = reg_wr_addr_reg;
    reg_wr_data_next = reg_wr_data_reg;
    if (line.stop_det) begin
      // pointer is left untouched: a send-byte keeps its value
      state_next = ST_IDLE;
      sda_oe_n_next = 1'b1;
    end else if (line.start_det) begin
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_n_next = 1'b1;
    end else if (line.scl_rise) begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          shift_in_next = {shift_in_reg[6:0], line.sda_level};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        ST_TX: bit_cnt_next = bit_cnt_reg + 4'h1;
        ST_TX_ACK: begin
          ack_seen_next = ~line.sda_level;
          if (!cbuf_reg) begin
            ptr_next = ptr_incr;
          end else if (line.sda_level) begin
            cbuf_next = 1'b0;
          end else if (ten_bit_mode && hi_phase_reg) begin
            hi_phase_next = 1'b0;
          end else begin
            hi_phase_next = 1'b1;
            samp_k_next = samp_k_incr;
          end
        end
        default: ;
      endcase
    end else if (line.scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          if (byte_done && addr_match) begin
            state_next = ST_ADDR_ACK;
            sda_oe_n_next = 1'b0;
            rw_next = shift_in_reg[0];
            first_byte_next = 1'b1;
            reject_next = 1'b0;
          end else if (byte_done) begin
            state_next = ST_IDLE;
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          bit_cnt_next = 4'h0;
          if (state_reg == ST_ADDR_ACK && rw_reg) begin
            state_next = ST_TX;
            tx_shift_next = tx_byte;
            sda_oe_n_next = tx_byte[7];
          end else begin
            state_next = ST_RX;
            sda_oe_n_next = 1'b1;
          end
        end
        ST_RX: begin
          if (byte_done) begin
            state_next = ST_RX_ACK;
            first_byte_next = 1'b0;
            if (first_byte_reg && (rx_is_cfg || rx_is_buf)) begin
              ptr_next = shift_in_reg;
              sda_oe_n_next = 1'b0;
              cbuf_next = rx_is_buf;
              samp_k_next = '0;
              hi_phase_next = 1'b1;
            end else if (first_byte_reg) begin
              reject_next = 1'b1;
            end else if (!reject_reg && ptr_reg <= PTR_CFG_MAX) begin
              sda_oe_n_next = 1'b0;
              reg_wr_en_next = 1'b1;
              reg_wr_addr_next = ptr_reg;
              reg_wr_data_next = shift_in_reg;
              ptr_next = ptr_incr;
            end
          end
        end
        ST_TX: begin
          if (byte_done) begin
            state_next = ST_TX_ACK;
            sda_oe_n_next = 1'b1;
          end else begin
            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
            sda_oe_n_next = tx_shift_reg[6];
          end
        end
        ST_TX_ACK: begin
          bit_cnt_next = 4'h0;
          if (ack_seen_reg) begin
            state_next = ST_TX;
            tx_shift_next = tx_byte;
            sda_oe_n_next = tx_byte[7];
          end else begin
            state_next = ST_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_in_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      sda_oe_n_reg <= 1'b1;
      rw_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_in_reg <= shift_in_next;
      tx_shift_reg <= tx_shift_next;
      sda_oe_n_reg <= sda_oe_n_next;
      rw_reg <= rw_next;
      first_byte_reg <= first_byte_next;
      reject_reg <= reject_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg <= PTR_RESET;
      cbuf_reg <= 1'b0;
      samp_k_reg <= '0;
      hi_phase_reg <= 1'b1;
      ack_seen_reg <= 1'b0;
      reg_wr_en_reg <= 1'b0;
      reg_wr_addr_reg <= PTR_RESET;
      reg_wr_data_reg <= 8'h00;
    end else begin
      ptr_reg <= ptr_next;
      cbuf_reg <= cbuf_next;
      samp_k_reg <= samp_k_next;
      hi_phase_reg <= hi_phase_next;
      ack_seen_reg <= ack_seen_next;
      reg_wr_en_reg <= reg_wr_en_next;
      reg_wr_addr_reg <= reg_wr_addr_next;
      reg_wr_data_reg <= reg_wr_data_next;
    end
  end

  // straps are pins: two flops each, and the address follows them live
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_lo_s1_reg <= 2'h0;
      strap_lo_s2_reg <= 2'h0;
      strap_hi_s1_reg <= 2'h0;
      strap_hi_s2_reg <= 2'h0;
      sda_out_reg <= 1'b0;
    end else begin
      strap_lo_s1_reg <= addr_strap_low;
      strap_lo_s2_reg <= strap_lo_s1_reg;
      strap_hi_s1_reg <= addr_strap_high;
      strap_hi_s2_reg <= strap_hi_s1_reg;
      sda_out_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain: only ever drives low, enable decides
  assign sda_out = sda_out_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign reg_rd_addr = ptr_reg;
  assign reg_wr_en = reg_wr_en_reg;
  assign reg_wr_addr = reg_wr_addr_reg;
  assign reg_wr_data = reg_wr_data_reg;
  assign cbuf_active = cbuf_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_stop_aborts: assert property (line.stop_det |=> state_reg == ST_IDLE && sda_oe_n_reg)
    else $error("stop did not abort the transfer");
  a_start_frames: assert property (line.start_det && !line.stop_det
      |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
    else $error("start did not open address phase");
  a_ack_held: assert property ((state_reg == ST_RX_ACK && !sda_oe_n_reg) && !line.scl_fall
      && !bus_event |=> !sda_oe_n_reg)
    else $error("acknowledge released before ninth clock ended");
  a_tx_ack_free: assert property (state_reg == ST_TX_ACK |-> sda_oe_n_reg)
    else $error("data line driven during master acknowledge");
  a_reboot_nack: assert property (state_reg == ST_ADDR && byte_done && line.scl_fall
      && reboot_busy && !bus_event |=> state_reg == ST_IDLE && sda_oe_n_reg)
    else $error("address acknowledged during reboot");
  a_bad_ptr_nack: assert property (state_reg == ST_RX && byte_done && first_byte_reg
      && line.scl_fall && !bus_event && shift_in_reg > PTR_BUF_LAST
      |=> state_reg == ST_RX_ACK && sda_oe_n_reg && reject_reg)
    else $error("out-of-range pointer was acknowledged");
  a_reject_quiet: assert property (reject_reg && state_reg == ST_RX
      |-> ##1 !reg_wr_en_reg)
    else $error("data stored after rejected command");
  a_ptr_wrap: assert property (reg_wr_en_reg && reg_wr_addr_reg == PTR_CFG_MAX
      |-> ptr_reg == PTR_RESET)
    else $error("pointer did not wrap to zero");
  a_wr_advance: assert property (reg_wr_en_reg && reg_wr_addr_reg < PTR_CFG_MAX
      |-> ptr_reg == reg_wr_addr_reg + 8'h01)
    else $error("pointer did not advance after write");
  a_cbuf_hold: assert property (cbuf_reg && state_reg == ST_TX_ACK && line.scl_rise
      |=> ptr_reg == $past(ptr_reg))
    else $error("pointer advanced during buffer read");
  a_cbuf_nack_end: assert property (cbuf_reg && state_reg == ST_TX_ACK && line.scl_rise
      && line.sda_level && !bus_event |=> !cbuf_reg ##[1:1000] state_reg == ST_IDLE)
    else $error("master nack did not end buffer read");
  a_phase_restart: assert property ($rose(cbuf_reg) |-> hi_phase_reg && samp_k_reg == '0)
    else $error("buffer read did not restart at high byte");

  c_write_store: cover property (reg_wr_en_reg ##[1:1000] line.stop_det);
  c_cbuf_stream: cover property ($rose(cbuf_reg) ##[1:1000] (state_reg == ST_TX_ACK
      && ack_seen_reg));
  c_read_nack: cover property (state_reg == ST_TX_ACK && line.scl_rise && line.sda_level);

endmodule : ssm_i2c_slave
`default_nettype wire

/* ssm_pkg.sv */
`default_nettype none
package ssm_pkg;

  // ----------------------------------------------------------------
  // pointer map and sample storage
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_CFG_MAX = 8'h45;
  localparam logic [7:0] PTR_BUF_FIRST = 8'h46;
  localparam logic [7:0] PTR_BUF_LAST = 8'h49;
  localparam int SAMPLE_W = 10;
  localparam int SAMPLE_DEPTH = 50;
  localparam int BUF_COUNT = 4;

  // ----------------------------------------------------------------
  // link framing and filtering
  // ----------------------------------------------------------------
  localparam logic [2:0] SLAVE_PREFIX = 3'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FILT_CYCLES = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STRAP_LOW = 2'h0,
    STRAP_HIGH = 2'h1,
    STRAP_OPEN = 2'h2
  } ssm_strap_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX = 7'h08,
    ST_RX_ACK = 7'h10,
    ST_TX = 7'h20,
    ST_TX_ACK = 7'h40
  } ssm_state_type;

endpackage : ssm_pkg
`default_nettype wire

/* ssm_line_if.sv */
`timescale 1ns/1ps
`default_nettype none
// filtered bus events handed from the line conditioner to the slave core
interface ssm_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic start_det;
  logic stop_det;
  modport src (output scl_rise, output scl_fall, output sda_level, output start_det,
    output stop_det);
  modport dst (input scl_rise, input scl_fall, input sda_level, input start_det,
    input stop_det);
endinterface : ssm_line_if
`default_nettype wire

/* ssm_line_cond.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_line_cond #(
  parameter int FILT = ssm_pkg::FILT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  ssm_line_if.src line
);
  import ssm_pkg::*;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [FILT-1:0] scl_hist_reg;
  logic [FILT-1:0] sda_hist_reg;
  logic scl_filt_reg;
  logic sda_filt_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // ----------------------------------------------------------------
  // two-stage synchronisers, then a stability filter
  // ----------------------------------------------------------------
  // a level only moves after FILT identical samples, so spikes shorter
  // than that never reach the edge logic
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_hist_reg <= '1;
      sda_hist_reg <= '1;
      scl_filt_reg <= 1'b1;
      sda_filt_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_hist_reg <= {scl_hist_reg[FILT-2:0], scl_sync_reg[1]};
      sda_hist_reg <= {sda_hist_reg[FILT-2:0], sda_sync_reg[1]};
      if (&scl_hist_reg || ~|scl_hist_reg) scl_filt_reg <= scl_hist_reg[0];
      if (&sda_hist_reg || ~|sda_hist_reg) sda_filt_reg <= sda_hist_reg[0];
      scl_prev_reg <= scl_filt_reg;
      sda_prev_reg <= sda_filt_reg;
    end
  end

  // ----------------------------------------------------------------
  // edge and condition decode
  // ----------------------------------------------------------------
  // data moving while the clock stays high frames a transfer
  assign line.scl_rise = scl_filt_reg & ~scl_prev_reg;
  assign line.scl_fall = ~scl_filt_reg & scl_prev_reg;
  assign line.sda_level = sda_filt_reg;
  assign line.start_det = scl_filt_reg & scl_prev_reg & sda_prev_reg & ~sda_filt_reg;
  assign line.stop_det = scl_filt_reg & scl_prev_reg & ~sda_prev_reg & sda_filt_reg;

endmodule : ssm_line_cond
`default_nettype wire

/* ssm_sample_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_sample_buf #(
  parameter int WIDTH = ssm_pkg::SAMPLE_W,
  parameter int DEPTH = ssm_pkg::SAMPLE_DEPTH,
  parameter int NBUF = ssm_pkg::BUF_COUNT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [$clog2(NBUF)-1:0] wr_sel,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(NBUF)-1:0] rd_sel,
  input wire logic [$clog2(DEPTH)-1:0] rd_k,
  output logic [WIDTH-1:0] rd_data
);
  import ssm_pkg::*;
  localparam int KW = $clog2(DEPTH);
  localparam int SW = $clog2(NBUF);

  logic [WIDTH-1:0] mem_reg [NBUF*DEPTH];
  logic [KW-1:0] head_reg [NBUF];

  function automatic int slot_index(input logic [SW-1:0] sel, input logic [KW-1:0] slot);
    slot_index = int'(sel) * DEPTH + int'(slot);
  endfunction : slot_index

  // ----------------------------------------------------------------
  // circular write side: head marks the oldest slot, next to be overwritten
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NBUF; b++) begin : g_head
    always_ff @(posedge clk) begin
      if (reset) head_reg[b] <= '0;
      else if (wr_en && wr_sel == SW'(b))
        head_reg[b] <= (head_reg[b] == KW'(DEPTH - 1)) ? '0 : head_reg[b] + KW'(1);
    end
  end

  // sample storage carries no reset; only the pointers need a known value
  always_ff @(posedge clk) begin
    if (wr_en) mem_reg[slot_index(wr_sel, head_reg[wr_sel])] <= wr_data;
  end

  // ----------------------------------------------------------------
  // readout order: second-oldest first, oldest last
  // ----------------------------------------------------------------
  wire [KW:0] rd_sum = {1'b0, head_reg[rd_sel]} + {1'b0, rd_k} + (KW + 1)'(1);
  wire [KW-1:0] rd_slot = (rd_sum >= (KW + 1)'(DEPTH)) ? KW'(rd_sum - (KW + 1)'(DEPTH))
                                                       : rd_sum[KW-1:0];
  assign rd_data = mem_reg[slot_index(rd_sel, rd_slot)];

endmodule : ssm_sample_buf
`default_nettype wire

/* ssm_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bus master model
// ------------------------------------------------------------
// host that makes the serial clock; a released data line reads the pull-up
module ssm_master_model (
  output logic scl,
  output logic sda_m,
  input wire logic sda_bus
);
  // low phase is long so the filtered slave drive settles before the rise
  localparam int T_LOW = 100;
  localparam int T_HIGH = 80;
  // idle high before the first frame
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // one bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    #(T_LOW / 2) sda_m = b;
    #(T_LOW / 2) scl = 1'b1;
    #(T_HIGH / 2) s = sda_bus;
    #(T_HIGH / 2) scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #(T_LOW / 2) sda_m = 1'b1;
    #(T_LOW / 2) scl = 1'b1;
    #(T_HIGH) sda_m = 1'b0;
    #(T_HIGH) scl = 1'b0;
  endtask : start
  task automatic stop();
    #(T_LOW / 2) sda_m = 1'b0;
    #(T_LOW / 2) scl = 1'b1;
    #(T_HIGH) sda_m = 1'b1;
    #(T_LOW);
  endtask : stop
  // eight bits msb first, then the ninth clock (0 = acknowledge)
  task automatic xfer(input logic [7:0] d, input logic ka, output logic [7:0] q,
    output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ka, a);
  endtask : xfer
endmodule : ssm_master_model
`default_nettype wire

/* i2c_slave_register_and_sample_readout_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_and_sample_readout_bench;
  import ssm_pkg::*;
  localparam logic [6:0] ADDR = 7'h35; // both straps high
  logic clk = 1'b0, reset = 1'b1, rb = 1'b0, tb = 1'b0, sw = 1'b0;
  logic [1:0] ss = 2'h0, sl = 2'h1, sh = 2'h1;
  logic [9:0] sd = 10'h000;
  logic scl, sda_m, sda_out, sda_oe_n, we, cba;
  logic [7:0] ra, wa, wd, mem [256];
  int failures = 0, n_tests = 0, nwr = 0;
  // open drain: only a low enable pulls the line down
  wire logic sda_bus = (sda_oe_n === 1'b0) ? sda_out : sda_m;
  always #5 clk = ~clk;
  // register bank on the far side of the pointer port
  always @(posedge clk) if (we === 1'b1) begin
    mem[wa] <= wd;
    nwr <= nwr + 1;
  end
  ssm_i2c_slave i_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_low(sl),
    .addr_strap_high(sh), .reboot_busy(rb), .ten_bit_mode(tb), .smp_wr(sw),
    .smp_sel(ss), .smp_data(sd), .reg_rd_addr(ra), .reg_rd_data(mem[ra]),
    .reg_wr_en(we), .reg_wr_addr(wa), .reg_wr_data(wd), .cbuf_active(cba));
  ssm_master_model i_master (.scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic a;
    i_master.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, {7'h0, e});
  endtask : tx
  task automatic rx(input logic ka, input logic [7:0] e);
    logic [7:0] q;
    logic a;
    i_master.xfer(8'hFF, ka, q, a);
    chk(q, e);
  endtask : rx
  function automatic logic [9:0] sv(input int i);
    return 10'(i * 20 + 3);
  endfunction : sv
  // pointer 0x45: the second byte wraps to 0x00, then a write after repeated start
  task automatic write_wrap();
    i_master.start();
    tx({ADDR, 1'b0}, 1'b0);
    tx(8'h45, 1'b0);
    tx(8'hA5, 1'b0);
    tx(8'h5A, 1'b0);
    i_master.start();
    tx({ADDR, 1'b0}, 1'b0);
    tx(8'h01, 1'b0);
    tx(8'hC3, 1'b0);
    i_master.stop();
    chk({7'h0, sda_out}, 8'h00);
    chk(mem[8'h45], 8'hA5);
    chk(mem[8'h00], 8'h5A);
    chk(mem[8'h01], 8'hC3);
  endtask : write_wrap
  // bad pointer, early stop, other address and reboot are all refused
  task automatic refused();
    logic s;
    int n;
    n = nwr;
    i_master.start();
    tx({ADDR, 1'b0}, 1'b0);
    tx(8'h4A, 1'b1);
    tx(8'h77, 1'b1);
    i_master.start();
    tx({ADDR, 1'b0}, 1'b0);
    tx(8'h10, 1'b0);
    repeat (3) i_master.bit_io(1'b0, s);
    i_master.stop();
    i_master.start();
    tx({ADDR ^ 7'h01, 1'b0}, 1'b1);
    i_master.stop();
    @(posedge clk) #1 rb = 1'b1;
    i_master.start();
    tx({ADDR, 1'b0}, 1'b1);
    i_master.stop();
    @(posedge clk) #1 rb = 1'b0;
    // high strap low, low strap open: address 011 10 00 must answer
    @(posedge clk) #1 {sh, sl} = {2'h0, 2'h2};
    i_master.start();
    tx({7'h38, 1'b0}, 1'b0);
    i_master.stop();
    @(posedge clk) #1 {sh, sl} = {2'h1, 2'h1};
    chk(8'(nwr - n), 8'h00);
  endtask : refused
  // send-byte, stop, then a two-byte receive across the wrap
  task automatic read_back();
    i_master.start();
    tx({ADDR, 1'b0}, 1'b0);
    tx(8'h45, 1'b0);
    i_master.stop();
    chk(ra, 8'h45);
    i_master.start();
    tx({ADDR, 1'b1}, 1'b0);
    rx(1'b0, 8'hA5);
    rx(1'b1, 8'h5A);
    i_master.stop();
  endtask : read_back
  // arm buffer base 0x47 and read it out
  task automatic arm(input logic [7:0] b);
    i_master.start();
    tx({ADDR, 1'b0}, 1'b0);
    tx(b, 1'b0);
    i_master.start();
    tx({ADDR, 1'b1}, 1'b0);
  endtask : arm
  task automatic buffer_read();
    logic [9:0] s;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk) #1 {sw, ss, sd} = {1'b1, 2'h1, sv(i)};
    end
    @(posedge clk) #1 sw = 1'b0;
    arm(8'h47);
    chk({7'h0, cba}, 8'h01);
    for (int k = 0; k < 50; k++) begin
      s = sv((k + 1) % 50);
      rx(k == 49, s[9:2]);
    end
    i_master.stop();
    chk({7'h0, cba}, 8'h00);
    chk(ra, 8'h47);
    @(posedge clk) #1 tb = 1'b1;
    s = sv(1);
    arm(8'h47);
    rx(1'b0, s[9:2]);
    rx(1'b0, {6'h00, s[1:0]});
    rx(1'b1, 8'(sv(2) >> 2));
    arm(8'h47);
    rx(1'b1, s[9:2]);
    i_master.stop();
  endtask : buffer_read
  task automatic tally_and_finish();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // main sequence; filters fill with idle-high before the first frame
  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    write_wrap();
    refused();
    read_back();
    buffer_read();
    tally_and_finish();
  end
  // watchdog well beyond the expected run of about 14k cycles
  initial begin
    #500000;
    failures++;
    tally_and_finish();
  end
endmodule : i2c_slave_register_and_sample_readout_bench
`default_nettype wire
